// >>> verilog/mgmt_map.svh
// register indices, field positions, reset values and timing counts
`ifndef MGMT_MAP_SVH
`define MGMT_MAP_SVH
`define ACC_INDEX 6
`define DATA_INDEX 7
`define PAUSE_INDEX 8
`define ACC_RESET 32'h0000_0000
`define DATA_RESET 32'h0000_0000
`define PAUSE_RESET 32'h0000_0000
`define ACC_PHY_MSB 15
`define ACC_PHY_LSB 11
`define ACC_REG_MSB 10
`define ACC_REG_LSB 6
`define ACC_WRITE_BIT 1
`define ACC_BUSY_BIT 0
`define DATA_MSB 15
`define PAUSE_TIME_MSB 31
`define PAUSE_TIME_LSB 16
`define PAUSE_PASS_BIT 2
`define PAUSE_EN_BIT 1
`define PAUSE_BUSY_BIT 0
`define INTERNAL_PHY_ADDR 5'h01
`define CLK_PERIOD_PS 4000
`define MDC_PERIOD_NS 400
`define MDC_HALF_CYCLES ((`MDC_PERIOD_NS * 1000 + 2 * `CLK_PERIOD_PS - 1) / (2 * `CLK_PERIOD_PS))
`define SLOT_TIME_NS 5120
`define SLOT_CYCLES ((`SLOT_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define MDIO_PREAMBLE 32'hffff_ffff
`define MDIO_SOF 2'h1
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_TA_WRITE 2'h2
`define MDIO_READ_FIRST 6'h30
`define MDIO_LAST_BIT 6'h3f
`define MDIO_RELEASE_BIT 6'h2d
`define PAUSE_DEST_ADDR 48'h0180_c200_0001
`define PAUSE_ETHERTYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`endif

// >>> verilog/mgmt_pkg.sv
// types shared by the management and pause control modules
package mgmt_pkg;
  typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} engine_state_type;
  typedef enum logic [1:0] {PS_IDLE, PS_SEND, PS_BACKPRESSURE} pause_state_type;

  typedef struct packed {
    engine_state_type state;
    logic wr;
    logic [15:0] div;
    logic mdc;
    logic [5:0] bit_cnt;
    logic [63:0] shreg;
    logic [15:0] rdata;
    logic out;
    logic oe;
    logic done;
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } engine_regs_type;

  typedef struct packed {
    logic [15:0] slot_cnt;
    logic [15:0] quanta_left;
    logic hold;
  } timer_regs_type;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] reg_idx;
    logic wr;
    logic busy;
    logic start;
    logic int_sel;
    logic [15:0] data;
    logic [15:0] pause_time;
    logic pass;
    logic flow_en;
    pause_state_type pstate;
    logic req_q;
    logic frame_req;
    logic [15:0] frame_time;
    logic [47:0] frame_dest;
    logic [15:0] frame_type;
    logic [15:0] frame_opcode;
    logic bp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] rx_data;
    logic rx_dv;
    logic rx_sv;
    logic rx_fp;
  } ctrl_regs_type;
endpackage

// >>> verilog/mgmt_req_if.sv
// request and answer between the register block and the serial engine
`timescale 1ns/1ps
interface mgmt_req_if;
  logic start;
  logic wr;
  logic [4:0] phy_addr;
  logic [4:0] reg_idx;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport ctrl (output start, wr, phy_addr, reg_idx, wdata, input done, rdata);
  modport engine (input start, wr, phy_addr, reg_idx, wdata, output done, rdata);
endinterface

// >>> verilog/mgmt_serial.sv
// serial management engine: one 64-bit frame per request
`timescale 1ns/1ps
`include "mgmt_map.svh"
module mgmt_serial #(
  parameter int MDC_HALF = `MDC_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  mgmt_req_if.engine req,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in
);
  mgmt_pkg::engine_regs_type r;
  mgmt_pkg::engine_regs_type n;

  // output changes after mdc falls, input is taken as mdc rises
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.s1 = mdio_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.filt = r.s3; // glitch filter: two stages must agree
    end
    case (r.state)
      mgmt_pkg::ENG_IDLE: begin
        if (req.start) begin
          n.state = mgmt_pkg::ENG_RUN;
          n.wr = req.wr;
          n.div = 16'h0;
          n.bit_cnt = 6'h0;
          n.mdc = 1'b0;
          n.shreg = {`MDIO_PREAMBLE, `MDIO_SOF, req.wr ? `MDIO_OP_WRITE : `MDIO_OP_READ,
                     req.phy_addr, req.reg_idx, req.wr ? `MDIO_TA_WRITE : 2'h0,
                     req.wr ? req.wdata : 16'h0};
          n.out = 1'b1;
          n.oe = 1'b1;
        end
      end
      default: begin
        if (r.div == 16'(MDC_HALF - 1)) begin
          n.div = 16'h0;
          n.mdc = ~r.mdc;
          if (!r.mdc) begin
            if (!r.wr && r.bit_cnt >= `MDIO_READ_FIRST) begin
              n.rdata = {r.rdata[14:0], r.filt};
            end
          end else if (r.bit_cnt == `MDIO_LAST_BIT) begin
            n.state = mgmt_pkg::ENG_IDLE;
            n.done = 1'b1;
            n.oe = 1'b0;
            n.out = 1'b0;
          end else begin
            n.bit_cnt = r.bit_cnt + 6'h1;
            n.shreg = {r.shreg[62:0], 1'b0};
            n.out = r.shreg[62];
            // read frames release the line for turnaround and data
            n.oe = r.wr || (r.bit_cnt < `MDIO_RELEASE_BIT);
          end
        end else begin
          n.div = r.div + 16'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mdc = r.mdc;
  assign mdio_out = r.out;
  assign mdio_oe = r.oe;
  assign req.done = r.done;
  assign req.rdata = r.rdata;

  a_read_release: assert property (@(posedge clk) disable iff (rst)
    (r.state == mgmt_pkg::ENG_RUN && !r.wr && r.bit_cnt > `MDIO_RELEASE_BIT) |-> !mdio_oe)
    else $error("engine drives the line during read data");
endmodule

// >>> verilog/pause_timer.sv
// transmit hold-off counter: pause quanta times slot time
`timescale 1ns/1ps
`include "mgmt_map.svh"
module pause_timer #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] quanta,
  output logic hold
);
  mgmt_pkg::timer_regs_type r;
  mgmt_pkg::timer_regs_type n;

  // a new pause frame restarts the count, zero quanta releases at once
  always_comb begin
    n = r;
    if (load) begin
      n.quanta_left = quanta;
      n.slot_cnt = 16'h0;
      n.hold = (quanta != 16'h0);
    end else if (r.hold) begin
      if (r.slot_cnt == 16'(SLOT_CYCLES - 1)) begin
        n.slot_cnt = 16'h0;
        n.quanta_left = r.quanta_left - 16'h1;
        n.hold = (r.quanta_left != 16'h1);
      end else begin
        n.slot_cnt = r.slot_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign hold = r.hold;

  // the last quantum must still hold until its final slot cycle
  a_single_quantum: assert property (@(posedge clk) disable iff (rst)
    (r.hold && !load && r.quanta_left == 16'h1 && r.slot_cnt != 16'(SLOT_CYCLES - 1))
    |=> hold)
    else $error("pause hold ended too early");
endmodule

// >>> verilog/phy_mgmt_and_pause_ctrl.sv
// apb register block for phy management access and pause flow control
`timescale 1ns/1ps
`include "mgmt_map.svh"

// How it works
// - phy address field picks target; internal is 1
// - register index field picks phy register
// - direction bit: write sends data, read fills it
// - software sets busy; hardware clears at end
// - read data invalid until busy clears
// - data low half holds read or write value
// - pause time field goes into pause frames
// - flow busy: until sent, or during backpressure
// - transmitter off: no pause, no backpressure
// - other pause fields per standard control frame
// - receive enable governs pause decoding and half-duplex backpressure
// - valid pause in full duplex is obeyed
// - pass bit marks control frames; else cleared
// - every received frame's data is forwarded
// - filtering modes override pass control setting
// - enable: pause in full, backpressure in half
// - hold transmitter for quanta times slot time
module phy_mgmt_and_pause_ctrl #(
  parameter int ADDR_W = 8,
  parameter int MDC_HALF = `MDC_HALF_CYCLES,
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in,
  output logic int_phy_select,
  input wire logic full_duplex,
  input wire logic tx_enable,
  input wire logic pause_request,
  input wire logic pause_frame_done,
  output logic pause_frame_req,
  output logic [15:0] pause_frame_time,
  output logic [47:0] pause_frame_dest,
  output logic [15:0] pause_frame_type,
  output logic [15:0] pause_frame_opcode,
  output logic backpressure,
  output logic tx_pause_hold,
  input wire logic rx_pause_valid,
  input wire logic [15:0] rx_pause_quanta,
  input wire logic [7:0] rx_data,
  input wire logic rx_data_valid,
  input wire logic rx_frame_end,
  input wire logic rx_is_control,
  input wire logic rx_addr_pass,
  input wire logic promiscuous,
  output logic [7:0] rx_data_out,
  output logic rx_data_out_valid,
  output logic rx_status_valid,
  output logic rx_status_filter_pass
);
  mgmt_pkg::ctrl_regs_type r;
  mgmt_pkg::ctrl_regs_type n;
  mgmt_req_if req ();
  logic apb_done;
  logic timer_load;

  // register index to byte address on the 32-bit bus
  function automatic logic [ADDR_W-1:0] reg_addr(input int idx);
    return ADDR_W'(idx * 4);
  endfunction

  // readback words: reserved bits are constant zero
  function automatic logic [31:0] acc_word(input mgmt_pkg::ctrl_regs_type s);
    logic [31:0] w;
    w = 32'h0;
    w[`ACC_PHY_MSB:`ACC_PHY_LSB] = s.phy_addr;
    w[`ACC_REG_MSB:`ACC_REG_LSB] = s.reg_idx;
    w[`ACC_WRITE_BIT] = s.wr;
    w[`ACC_BUSY_BIT] = s.busy;
    return w;
  endfunction

  function automatic logic [31:0] pause_word(input mgmt_pkg::ctrl_regs_type s);
    logic [31:0] w;
    w = 32'h0;
    w[`PAUSE_TIME_MSB:`PAUSE_TIME_LSB] = s.pause_time;
    w[`PAUSE_PASS_BIT] = s.pass;
    w[`PAUSE_EN_BIT] = s.flow_en;
    w[`PAUSE_BUSY_BIT] = (s.pstate != mgmt_pkg::PS_IDLE);
    return w;
  endfunction

  // the completing edge of an apb transfer
  assign apb_done = psel && penable && r.pready;
  // pause decoding only when receive flow enable is on in full duplex
  assign timer_load = rx_pause_valid && r.flow_en && full_duplex;

  always_comb begin
    n = r;
    n.start = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.rx_sv = 1'b0;
    // one wait state so the answer comes from flops
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      if (paddr == reg_addr(`ACC_INDEX)) begin
        n.prdata = acc_word(r);
      end else if (paddr == reg_addr(`DATA_INDEX)) begin
        n.prdata = {16'h0, r.data};
      end else if (paddr == reg_addr(`PAUSE_INDEX)) begin
        n.prdata = pause_word(r);
      end else begin
        n.pslverr = 1'b1;
      end
    end
    // writes take effect on the completing edge only
    if (apb_done && pwrite) begin
      if (paddr == reg_addr(`ACC_INDEX)) begin
        // a write while busy is dropped so a running frame is never disturbed
        if (!r.busy) begin
          n.phy_addr = pwdata[`ACC_PHY_MSB:`ACC_PHY_LSB];
          n.reg_idx = pwdata[`ACC_REG_MSB:`ACC_REG_LSB];
          n.wr = pwdata[`ACC_WRITE_BIT];
          n.busy = pwdata[`ACC_BUSY_BIT];
          n.start = pwdata[`ACC_BUSY_BIT];
          n.int_sel = (pwdata[`ACC_PHY_MSB:`ACC_PHY_LSB] == `INTERNAL_PHY_ADDR);
        end
      end else if (paddr == reg_addr(`DATA_INDEX)) begin
        if (!r.busy) begin
          n.data = pwdata[`DATA_MSB:0];
        end
      end else if (paddr == reg_addr(`PAUSE_INDEX)) begin
        // the busy bit position is read only; whatever is written there is lost
        n.pause_time = pwdata[`PAUSE_TIME_MSB:`PAUSE_TIME_LSB];
        n.pass = pwdata[`PAUSE_PASS_BIT];
        n.flow_en = pwdata[`PAUSE_EN_BIT];
      end
    end
    // end of a serial transaction
    if (r.busy && req.done) begin
      n.busy = 1'b0;
      if (!r.wr) begin
        n.data = req.rdata;
      end
    end
    // pause generation and backpressure
    n.req_q = pause_request;
    case (r.pstate)
      mgmt_pkg::PS_IDLE: begin
        if (tx_enable && full_duplex && pause_request && !r.req_q) begin
          n.pstate = mgmt_pkg::PS_SEND;
          n.frame_req = 1'b1;
          n.frame_time = r.pause_time;
          n.frame_dest = `PAUSE_DEST_ADDR;
          n.frame_type = `PAUSE_ETHERTYPE;
          n.frame_opcode = `PAUSE_OPCODE;
        end else if (tx_enable && !full_duplex && r.flow_en && pause_request) begin
          n.pstate = mgmt_pkg::PS_BACKPRESSURE;
          n.bp = 1'b1;
        end
      end
      mgmt_pkg::PS_SEND: begin
        // busy lasts until the frame has left; a disabled transmitter aborts it
        if (pause_frame_done || !tx_enable) begin
          n.pstate = mgmt_pkg::PS_IDLE;
          n.frame_req = 1'b0;
        end
      end
      default: begin
        if (!tx_enable || full_duplex || !r.flow_en || !pause_request) begin
          n.pstate = mgmt_pkg::PS_IDLE;
          n.bp = 1'b0;
        end
      end
    endcase
    // receive data passes on unconditionally, status tells the keeper
    n.rx_data = rx_data;
    n.rx_dv = rx_data_valid;
    if (rx_frame_end) begin
      n.rx_sv = 1'b1;
      if (promiscuous) begin
        n.rx_fp = 1'b1;
      end else if (rx_is_control) begin
        n.rx_fp = r.pass;
      end else begin
        n.rx_fp = rx_addr_pass;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // request side of the serial engine
  assign req.start = r.start;
  assign req.wr = r.wr;
  assign req.phy_addr = r.phy_addr;
  assign req.reg_idx = r.reg_idx;
  assign req.wdata = r.data;

  mgmt_serial #(
    .MDC_HALF(MDC_HALF)
  ) u_serial (
    .clk(clk),
    .rst(rst),
    .req(req.engine),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .mdio_in(mdio_in)
  );

  pause_timer #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .load(timer_load),
    .quanta(rx_pause_quanta),
    .hold(tx_pause_hold)
  );

  // outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign int_phy_select = r.int_sel;
  assign pause_frame_req = r.frame_req;
  assign pause_frame_time = r.frame_time;
  assign pause_frame_dest = r.frame_dest;
  assign pause_frame_type = r.frame_type;
  assign pause_frame_opcode = r.frame_opcode;
  assign backpressure = r.bp;
  assign rx_data_out = r.rx_data;
  assign rx_data_out_valid = r.rx_dv;
  assign rx_status_valid = r.rx_sv;
  assign rx_status_filter_pass = r.rx_fp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // checks on the register side, the pause side and the receive side

  a_access_start: assert property (
    (apb_done && pwrite && paddr == reg_addr(`ACC_INDEX) && !r.busy && pwdata[0])
    |=> (r.busy && r.start ##1 r.busy && !r.start))
    else $error("access did not start with busy set");
  a_busy_held: assert property (
    (r.busy && !req.done) |=> r.busy)
    else $error("busy dropped before the transaction ended");
  a_read_capture: assert property (
    (r.busy && req.done && !r.wr) |=> (!r.busy && r.data == $past(req.rdata)))
    else $error("read data not placed in data register");
  a_write_data_kept: assert property (
    (r.busy && $past(r.busy)) |-> $stable(r.data))
    else $error("data register changed during access");
  a_internal_select: assert property (
    r.start |-> (int_phy_select == (r.phy_addr == `INTERNAL_PHY_ADDR)))
    else $error("internal phy select wrong");
  a_pause_time: assert property (
    $rose(pause_frame_req) |-> (pause_frame_time == r.pause_time
      && pause_frame_opcode == `PAUSE_OPCODE))
    else $error("pause frame fields wrong");
  a_tx_off_quiet: assert property (
    !tx_enable |=> (!backpressure && !pause_frame_req))
    else $error("pause activity with transmitter off");
  a_flow_busy: assert property (
    (pause_frame_req || backpressure) |-> ((pause_word(r) & 32'h0000_0001) != 32'h0))
    else $error("flow busy clear while pausing");
  a_ctl_blocked: assert property (
    (rx_frame_end && rx_is_control && !r.pass && !promiscuous)
    |=> (rx_status_valid && !rx_status_filter_pass))
    else $error("control frame marked as passed");
  a_promisc_wins: assert property (
    (rx_frame_end && promiscuous) |=> rx_status_filter_pass)
    else $error("filter mode did not take precedence");
  a_rx_forward: assert property (
    rx_data_valid |=> (rx_data_out_valid && rx_data_out == $past(rx_data)))
    else $error("received data not forwarded");
  a_pause_obeyed: assert property (
    (timer_load && rx_pause_quanta != 16'h0) |=> tx_pause_hold [*2])
    else $error("valid pause not obeyed");
  a_decode_off: assert property (
    (!tx_pause_hold && !(r.flow_en && full_duplex)) |=> !tx_pause_hold)
    else $error("pause decoded with receive flow disabled");
  // reserved positions differ per register, so the address picks the mask
  a_reserved_zero: assert property (
    (pready && !pslverr) |-> ((paddr == reg_addr(`PAUSE_INDEX)) ? (prdata[15:3] == 13'h0)
      : (prdata[31:16] == 16'h0 && (paddr != reg_addr(`ACC_INDEX) || prdata[5:2] == 4'h0))))
    else $error("reserved bits read nonzero");
  a_apb_answer: assert property (
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");

  // unmapped addresses answer with an error and zero data, never a write
  a_unmapped_error: assert property (
    (psel && penable && !pready && paddr != reg_addr(`ACC_INDEX)
      && paddr != reg_addr(`DATA_INDEX) && paddr != reg_addr(`PAUSE_INDEX))
    |=> (pslverr && prdata == 32'h0))
    else $error("unmapped address not refused");
  // a data write during an access must not disturb the frame being sent
  a_data_refused: assert property (
    (apb_done && pwrite && paddr == reg_addr(`DATA_INDEX) && r.busy && !req.done)
    |=> $stable(r.data))
    else $error("data register written while busy");
  // half duplex: backpressure follows the request while enabled
  a_backpressure_on: assert property (
    (r.pstate == mgmt_pkg::PS_IDLE && tx_enable && !full_duplex && r.flow_en
      && pause_request) |=> backpressure)
    else $error("backpressure not raised");
  // full duplex: the request stands until the frame has left
  a_frame_held: assert property (
    (pause_frame_req && !pause_frame_done && tx_enable) |=> pause_frame_req)
    else $error("pause frame request dropped early");
  a_ctl_passed: assert property (
    (rx_frame_end && rx_is_control && r.pass && !promiscuous) |=> rx_status_filter_pass)
    else $error("control frame not marked as passed");

  // main scenarios for coverage

  c_phy_write: cover property (r.busy && r.wr ##[1:1000] req.done);
  c_phy_read: cover property (r.busy && !r.wr ##[1:1000] req.done);
  c_pause_sent: cover property ($rose(pause_frame_req) ##[1:100] pause_frame_done);
  c_backpressure: cover property ($rose(backpressure));
  c_rx_pause: cover property (timer_load ##1 tx_pause_hold);
endmodule

// >>> verif/phy_mdio_model.sv
// behavioural phy management port: a register file answering serial frames
`timescale 1ns/1ps
module phy_mdio_model (
  input wire logic mdc,
  input wire logic mdio_line,
  output logic mdio_drv,
  output logic [4:0] last_phy,
  output logic [4:0] last_reg,
  output logic last_wr,
  output logic [15:0] last_data
);
  logic [15:0] mem [32];
  logic [31:0] sh;
  int rel;
  int ones;
  initial begin
    mdio_drv = 1'b1;
    last_wr = 1'b1;
    rel = 0;
    ones = 0;
    foreach (mem[i]) mem[i] = 16'h5a00 + 16'(i);
  end
  // sample the wire on the rising clock; a frame starts at the zero after the ones
  always @(posedge mdc) begin
    if (rel != 0 || (mdio_line == 1'b0 && ones > 30)) begin
      sh = {sh[30:0], mdio_line};
      rel = rel + 1;
      ones = 0;
    end else begin
      ones = mdio_line ? ones + 1 : 0;
    end
    if (rel == 14) begin
      last_wr = (sh[11:10] == 2'b01);
      last_phy = sh[9:5];
      last_reg = sh[4:0];
    end
    if (rel == 32) begin
      if (last_wr) mem[last_reg] = sh[15:0];
      last_data = sh[15:0];
      rel = 0;
    end
  end
  // answer reads after the falling clock; released line floats high on its pull-up
  always @(negedge mdc) begin
    if (!last_wr && rel == 15) mdio_drv = 1'b0;
    else if (!last_wr && rel >= 16 && rel < 32) mdio_drv = mem[last_reg][31 - rel];
    else mdio_drv = 1'b1;
  end
endmodule

// >>> verif/test_phy_mgmt_and_pause_ctrl.sv
// self-checking bench for the phy management and pause control block
`timescale 1ns/1ps
`include "mgmt_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_phy_mgmt_and_pause_ctrl;
  localparam logic [7:0] ACC_A = 8'(`ACC_INDEX * 4);
  localparam logic [7:0] DAT_A = 8'(`DATA_INDEX * 4);
  localparam logic [7:0] PAU_A = 8'(`PAUSE_INDEX * 4);
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, rx_data, rx_data_out;
  logic [31:0] pwdata, prdata, rdata;
  logic mdc, mdio_out, mdio_oe, mdio_in, phy_drv, int_phy_select, full_duplex, tx_enable;
  logic pause_request, pause_frame_done, pause_frame_req, backpressure, tx_pause_hold;
  logic [15:0] pf_time, pf_type, pf_op, rx_pause_quanta, m_data;
  logic [47:0] pf_dest;
  logic rx_pause_valid, rx_data_valid, rx_frame_end, rx_is_control, rx_addr_pass;
  logic promiscuous, rx_data_out_valid, rx_status_valid, rx_status_filter_pass, m_wr;
  logic [4:0] m_phy, m_reg;
  int fail_count = 0;
  int checks_done = 0;
  int n;

  // the line is the design's level while it drives, otherwise the phy's
  assign mdio_in = mdio_oe ? mdio_out : phy_drv;

  phy_mgmt_and_pause_ctrl #(.MDC_HALF(8), .SLOT_CYCLES(4)) uut (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mdc, .mdio_out, .mdio_oe,
    .mdio_in, .int_phy_select, .full_duplex, .tx_enable, .pause_request, .pause_frame_done,
    .pause_frame_req, .pause_frame_time(pf_time), .pause_frame_dest(pf_dest),
    .pause_frame_type(pf_type), .pause_frame_opcode(pf_op), .backpressure, .tx_pause_hold,
    .rx_pause_valid, .rx_pause_quanta, .rx_data, .rx_data_valid, .rx_frame_end,
    .rx_is_control, .rx_addr_pass, .promiscuous, .rx_data_out, .rx_data_out_valid,
    .rx_status_valid, .rx_status_filter_pass);

  phy_mdio_model phy (.mdc, .mdio_line(mdio_in), .mdio_drv(phy_drv), .last_phy(m_phy),
    .last_reg(m_reg), .last_wr(m_wr), .last_data(m_data));

  // one apb transfer; entered right after a rising edge, leaves one idle edge behind
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_count++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdata, e)
  endtask

  // poll the busy bit, bounded so a stuck access cannot hang the run
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, ACC_A, 32'h0000_0000);
      k++;
    end while (rdata[0] !== 1'b0 && k < 1000);
    `CHK(rdata[0], 1'b0)
  endtask

  // received pause of three quanta; count the cycles the transmitter is held
  task automatic rx_pause(input int e);
    rx_pause_quanta <= 16'h0003;
    rx_pause_valid <= 1'b1;
    @(posedge clk);
    rx_pause_valid <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (tx_pause_hold === 1'b1) n++;
    end
    `CHK(n, e)
  endtask

  task automatic wrap_up();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // watchdog: two phy accesses need about 2100 cycles, the rest a few hundred
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {full_duplex, tx_enable, pause_request, pause_frame_done, rx_pause_valid} = 5'h00;
    {rx_pause_quanta, rx_data, rx_data_valid, rx_frame_end} = 26'h0;
    {rx_is_control, rx_addr_pass, promiscuous} = 3'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(ACC_A, 32'h0000_0000);
    rdchk(DAT_A, 32'h0000_0000);
    rdchk(PAU_A, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK({rerr, rdata}, {1'b1, 32'h0000_0000})
    apb(1'b1, PAU_A, 32'hffff_fffe);
    rdchk(PAU_A, 32'hffff_0006);
    // phy write with reserved bits set, then a data write refused while busy
    apb(1'b1, DAT_A, 32'hffff_beef);
    rdchk(DAT_A, 32'h0000_beef);
    apb(1'b1, ACC_A, {16'hffff, 5'h01, 5'h05, 4'hf, 2'b11});
    rdchk(ACC_A, {16'h0000, 5'h01, 5'h05, 4'h0, 2'b11});
    `CHK(int_phy_select, 1'b1)
    apb(1'b1, DAT_A, 32'h0000_1111);
    wait_idle();
    rdchk(DAT_A, 32'h0000_beef);
    `CHK({m_wr, m_phy, m_reg, m_data}, {1'b1, 5'h01, 5'h05, 16'hbeef})
    // phy read from an external address
    apb(1'b1, ACC_A, {16'h0000, 5'h03, 5'h09, 4'h0, 2'b01});
    rdchk(ACC_A, {16'h0000, 5'h03, 5'h09, 4'h0, 2'b01});
    `CHK(int_phy_select, 1'b0)
    wait_idle();
    rdchk(DAT_A, 32'h0000_5a09);
    `CHK({m_wr, m_phy, m_reg}, {1'b0, 5'h03, 5'h09})
    // full-duplex pause frame request and its busy flag
    full_duplex <= 1'b1;
    tx_enable <= 1'b1;
    apb(1'b1, PAU_A, 32'h1234_0002);
    pause_request <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({pause_frame_req, pf_time}, {1'b1, 16'h1234})
    `CHK({pf_dest, pf_type, pf_op}, {`PAUSE_DEST_ADDR, `PAUSE_ETHERTYPE, `PAUSE_OPCODE})
    rdchk(PAU_A, 32'h1234_0003);
    pause_frame_done <= 1'b1;
    pause_request <= 1'b0;
    @(posedge clk);
    pause_frame_done <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(PAU_A, 32'h1234_0002);
    rx_pause(12);
    apb(1'b1, PAU_A, 32'h1234_0000);
    rx_pause(0);
    // transmitter off: neither pause frame nor backpressure
    apb(1'b1, PAU_A, 32'h1234_0002);
    tx_enable <= 1'b0;
    pause_request <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({pause_frame_req, backpressure}, 2'b00)
    full_duplex <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(backpressure, 1'b0)
    tx_enable <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(backpressure, 1'b1)
    rdchk(PAU_A, 32'h1234_0003);
    pause_request <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(backpressure, 1'b0)
    // every mix of promiscuous, control, address pass and pass bit
    for (int i = 0; i < 16; i++) begin
      if (i == 0 || i == 8) apb(1'b1, PAU_A, {29'h0, i[3], 2'b00});
      promiscuous <= i[0];
      rx_is_control <= i[1];
      rx_addr_pass <= i[2];
      rx_frame_end <= 1'b1;
      rx_data <= 8'(i * 17 + 3);
      rx_data_valid <= 1'b1;
      @(posedge clk);
      rx_frame_end <= 1'b0;
      rx_data_valid <= 1'b0;
      @(posedge clk);
      `CHK({rx_status_valid, rx_data_out_valid, rx_data_out}, {2'b11, 8'(i * 17 + 3)})
      `CHK(rx_status_filter_pass, i[0] | (i[1] ? i[3] : i[2]))
    end
    wrap_up();
  end
endmodule
